// ### src/rffl_pkg.sv
// Constants and field layouts for the RF front-end serial latch bank
// Functional notes
// - Host shifts 24-bit words MSB first.
// - Strobe rising edge loads latch by bits 1:0.
// - Select 00 loads control latch, third bit ignored.
// - Four sleep bits power down their sections.
// - Oscillator outputs muted until lock when enabled.
// - Transmit outputs muted until lock when enabled.
// - Pump tristate bit floats charge pump output.
// - Polarity bit selects phase detector sense.
// - Counter hold keeps PLL counters in reset.
// - Select 001 loads transmit latch.
// - Select 101 loads receive calibration latch.
// - Demod phase picks 90 degree steps or off.
// - Mixer phase picks quadrature or single phase.
// - Reference divider is 13-bit straight binary.
// - Calibration latch load with bit set starts calibration.
// - 6-bit divider makes calibration clock from reference.
// - Boost lasts timeout times calibration period.
// - Zero timeout hands boost to manual bit.
// - Select 10 loads oscillator divider latch.
// - Select 11 loads receive filter latch.
// - Manual boost bit enables filter charge boost.
// - Output level applied; pump current applied, or forced to maximum when pump_gain_max is set.
package rffl_pkg;

    localparam int WORD_W = 24;
    localparam int SEL_W = 2;
    localparam int SUB_BIT = 2;
    localparam int CAL_DIV_W = 6;
    localparam int TIMEOUT_W = 6;

    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_TXCAL = 2'h1;
    localparam logic [1:0] SEL_LO = 2'h2;
    localparam logic [1:0] SEL_RX = 2'h3;
    localparam logic SUB_TX = 1'h0;
    localparam logic SUB_CAL = 1'h1;

    localparam logic [2:0] PHASE_OFF = 3'h7;
    localparam logic [2:0] MIX_QUAD = 3'h0;
    localparam logic [5:0] TIMEOUT_MANUAL = 6'h00;

    // Sections asleep and LO phase off out of reset, as a safe start-up
    localparam logic [23:0] CTRL_RST = 24'h780000;
    localparam logic [23:0] TX_RST = 24'hE30000;
    localparam logic [23:0] ZERO_RST = 24'h000000;

    typedef enum logic [2:0] {DST_NONE, DST_CTRL, DST_TX, DST_CAL, DST_LO, DST_RX} rffl_dest_t;

    typedef struct packed {
        logic reserved;
        logic rx_filter_sleep;
        logic pll_sleep;
        logic oscillator_sleep;
        logic transmit_sleep;
        logic out_level_high_bit;
        logic out_level_low_bit;
        logic [2:0] pump_current_sel;
        logic [1:0] lo_level_sel;
        logic osc_mute_until_lock;
        logic transmit_mute_until_lock;
        logic pump_tristate;
        logic detector_polarity;
        logic [2:0] monitor_output_sel;
        logic pll_counter_hold;
        logic [1:0] spare;
        logic [1:0] latch_select_bits;
    } rffl_ctrl_t;

    typedef struct packed {
        logic [2:0] demod_phase_sel;
        logic [2:0] mixer_phase_sel;
        logic [1:0] band_clock_divider;
    } rffl_phase_t;

    typedef struct packed {
        rffl_phase_t phase;
        logic [12:0] ref_divide_ratio;
        logic [2:0] latch_select_bits;
    } rffl_tx_t;

    typedef struct packed {
        rffl_phase_t phase;
        logic cutoff_cal_start;
        logic [5:0] cal_clock_divider;
        logic [5:0] boost_timeout_count;
        logic [2:0] latch_select_bits;
    } rffl_cal_t;

    typedef struct packed {
        logic [1:0] prescaler_sel;
        logic pump_gain_max;
        logic feedback_mux_sel;
        logic [12:0] main_divide_count;
        logic [4:0] swallow_count;
        logic [1:0] latch_select_bits;
    } rffl_lo_t;

    typedef struct packed {
        logic [15:0] factory_test_field;
        logic filter_charge_boost_enable;
        logic [1:0] rx_filter_bandwidth_sel;
        logic [2:0] rx_gain_sel;
        logic [1:0] latch_select_bits;
    } rffl_rx_t;

endpackage

// ### src/rffl_edge_det.sv
// Rising-edge detector for synchronous pin levels
`timescale 1ns/100ps
module rffl_edge_det import rffl_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] prev_q;
    logic [W-1:0] prev_d;

    always_comb begin
        prev_d = level;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prev_q <= '0;
        end else if (ce) begin
            prev_q <= prev_d;
        end
    end

    assign rise = level & ~prev_q;
endmodule // rffl_edge_det

// ### src/rffl_boost_timer.sv
// Calibration clock divider and high-pass boost timeout counter
`timescale 1ns/100ps
module rffl_boost_timer import rffl_pkg::*; #(
    parameter int DIV_W = CAL_DIV_W,
    parameter int CNT_W = TIMEOUT_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic ref_tick,
    input wire logic start,
    input wire logic [DIV_W-1:0] div_ratio,
    input wire logic [CNT_W-1:0] count,
    output logic busy
);
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic [CNT_W-1:0] rem_q;
    logic [CNT_W-1:0] rem_d;
    logic [DIV_W:0] div_next;
    logic cal_tick;

    always_comb begin
        div_d = div_q;
        rem_d = rem_q;
        cal_tick = 1'b0;
        div_next = {1'b0, div_q} + 1'b1;
        // Divider restarts on load so the boost spans whole periods
        if (start) begin
            div_d = '0;
            rem_d = count;
        end else if (ref_tick) begin
            // Ratio of zero behaves as one
            if (div_next >= {1'b0, div_ratio}) begin
                div_d = '0;
                cal_tick = 1'b1;
            end else begin
                div_d = div_next[DIV_W-1:0];
            end
            if (cal_tick && rem_q != '0) begin
                rem_d = rem_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            div_q <= '0;
            rem_q <= '0;
        end else if (ce) begin
            div_q <= div_d;
            rem_q <= rem_d;
        end
    end

    assign busy = rem_q != '0;
endmodule // rffl_boost_timer

// ### src/rffl_latch_bank.sv
// Serial write port and configuration latch bank of the RF front end
`timescale 1ns/100ps
module rffl_latch_bank import rffl_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    input wire logic pll_lock,
    input wire logic ref_tick,
    output logic rx_filter_sleep,
    output logic pll_sleep,
    output logic oscillator_sleep,
    output logic transmit_sleep,
    output logic [1:0] out_level_sel,
    output logic [1:0] lo_level_sel,
    output logic [2:0] pump_current_sel,
    output logic osc_out_enable,
    output logic transmit_out_enable,
    output logic pump_tristate,
    output logic detector_polarity,
    output logic [2:0] monitor_output_sel,
    output logic pll_counter_hold,
    output logic rx_lo_enable,
    output logic [1:0] rx_lo_phase,
    output logic mixer_quadrature,
    output logic mixer_single_q,
    output logic [2:0] mixer_phase_sel,
    output logic [1:0] band_clock_divider,
    output logic [12:0] ref_divide_ratio,
    output logic cutoff_cal_start,
    output logic [5:0] cal_clock_divider,
    output logic filter_charge_boost,
    output logic [1:0] prescaler_sel,
    output logic feedback_mux_sel,
    output logic [12:0] main_divide_count,
    output logic [4:0] swallow_count,
    output logic [1:0] rx_filter_bandwidth_sel,
    output logic [2:0] rx_gain_sel,
    output logic [15:0] factory_test_field
);
    // Reset image of the transmit latch, for the shared phase fields
    localparam rffl_tx_t TX_RST_VIEW = rffl_tx_t'(TX_RST);

    logic sclk_rise;
    logic strobe_rise;
    logic timer_busy;
    rffl_dest_t dest;

    logic [WORD_W-1:0] shift_q;
    logic [WORD_W-1:0] shift_d;
    rffl_ctrl_t ctrl_q;
    rffl_ctrl_t ctrl_d;
    rffl_tx_t tx_q;
    rffl_tx_t tx_d;
    rffl_cal_t cal_q;
    rffl_cal_t cal_d;
    rffl_lo_t lo_q;
    rffl_lo_t lo_d;
    rffl_rx_t rx_q;
    rffl_rx_t rx_d;
    rffl_phase_t phase_q;
    rffl_phase_t phase_d;
    rffl_cal_t shift_cal;
    logic lo_en_q;
    logic lo_en_d;
    logic quad_q;
    logic quad_d;

    logic osc_en_q;
    logic osc_en_d;
    logic tx_en_q;
    logic tx_en_d;
    logic cal_start_q;
    logic cal_start_d;
    logic boost_q;
    logic boost_d;
    logic [2:0] pump_q;
    logic [2:0] pump_d;

    rffl_edge_det #(.W(1)) u_sclk_edge (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .level(sclk),
        .rise(sclk_rise)
    );

    rffl_edge_det #(.W(1)) u_strobe_edge (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .level(load_strobe),
        .rise(strobe_rise)
    );

    // Calibration view of the word waiting in the shift register
    assign shift_cal = rffl_cal_t'(shift_q);

    // Destination decode from the low select bits of the shift register
    always_comb begin
        dest = DST_NONE;
        if (strobe_rise) begin
            case (shift_q[SEL_W-1:0])
                SEL_CTRL: dest = DST_CTRL;
                SEL_TXCAL: dest = (shift_q[SUB_BIT] == SUB_CAL) ? DST_CAL : DST_TX;
                SEL_LO: dest = DST_LO;
                SEL_RX: dest = DST_RX;
                default: dest = DST_NONE;
            endcase
        end
    end

    always_comb begin
        shift_d = shift_q;
        ctrl_d = ctrl_q;
        tx_d = tx_q;
        cal_d = cal_q;
        lo_d = lo_q;
        rx_d = rx_q;
        phase_d = phase_q;
        // Old word is latched if a strobe meets a clock edge
        if (sclk_rise) begin
            shift_d = {shift_q[WORD_W-2:0], sdata};
        end
        // Each latch changes only on its own strobe
        case (dest)
            DST_CTRL: ctrl_d = rffl_ctrl_t'(shift_q);
            DST_TX: begin
                tx_d = rffl_tx_t'(shift_q);
                phase_d = tx_d.phase;
            end
            DST_CAL: begin
                cal_d = rffl_cal_t'(shift_q);
                phase_d = cal_d.phase;
            end
            DST_LO: lo_d = rffl_lo_t'(shift_q);
            DST_RX: rx_d = rffl_rx_t'(shift_q);
            default: ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            shift_q <= ZERO_RST;
            ctrl_q <= rffl_ctrl_t'(CTRL_RST);
            tx_q <= rffl_tx_t'(TX_RST);
            cal_q <= rffl_cal_t'(ZERO_RST);
            lo_q <= rffl_lo_t'(ZERO_RST);
            rx_q <= rffl_rx_t'(ZERO_RST);
            phase_q <= TX_RST_VIEW.phase;
        end else if (ce) begin
            shift_q <= shift_d;
            ctrl_q <= ctrl_d;
            tx_q <= tx_d;
            cal_q <= cal_d;
            lo_q <= lo_d;
            rx_q <= rx_d;
            phase_q <= phase_d;
        end
    end

    rffl_boost_timer #(.DIV_W(CAL_DIV_W), .CNT_W(TIMEOUT_W)) u_boost (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .ref_tick(ref_tick),
        .start(dest == DST_CAL),
        .div_ratio(cal_q.cal_clock_divider),
        .count(shift_cal.boost_timeout_count),
        .busy(timer_busy)
    );

    // Derived controls, registered so every output leaves a flop
    always_comb begin
        // Lock only gates the outputs; it never alters the stored bits
        osc_en_d = !ctrl_q.oscillator_sleep && !(ctrl_q.osc_mute_until_lock && !pll_lock);
        tx_en_d = !ctrl_q.transmit_sleep
            && !(ctrl_q.transmit_mute_until_lock && !pll_lock);
        pump_d = lo_q.pump_gain_max ? '1 : ctrl_q.pump_current_sel;
        cal_start_d = (dest == DST_CAL) && shift_cal.cutoff_cal_start;
        // Phase decode kept in flops so these outputs leave a register
        lo_en_d = phase_d.demod_phase_sel != PHASE_OFF;
        quad_d = phase_d.mixer_phase_sel == MIX_QUAD;
        if (cal_q.boost_timeout_count == TIMEOUT_MANUAL) begin
            boost_d = rx_q.filter_charge_boost_enable;
        end else begin
            boost_d = timer_busy;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            osc_en_q <= 1'b0;
            tx_en_q <= 1'b0;
            pump_q <= '0;
            cal_start_q <= 1'b0;
            boost_q <= 1'b0;
            lo_en_q <= TX_RST_VIEW.phase.demod_phase_sel != PHASE_OFF;
            quad_q <= TX_RST_VIEW.phase.mixer_phase_sel == MIX_QUAD;
        end else if (ce) begin
            osc_en_q <= osc_en_d;
            tx_en_q <= tx_en_d;
            pump_q <= pump_d;
            cal_start_q <= cal_start_d;
            boost_q <= boost_d;
            lo_en_q <= lo_en_d;
            quad_q <= quad_d;
        end
    end

    assign rx_filter_sleep = ctrl_q.rx_filter_sleep;
    assign pll_sleep = ctrl_q.pll_sleep;
    assign oscillator_sleep = ctrl_q.oscillator_sleep;
    assign transmit_sleep = ctrl_q.transmit_sleep;
    assign out_level_sel = {ctrl_q.out_level_high_bit, ctrl_q.out_level_low_bit};
    assign lo_level_sel = ctrl_q.lo_level_sel;
    assign pump_current_sel = pump_q;
    assign osc_out_enable = osc_en_q;
    assign transmit_out_enable = tx_en_q;
    assign pump_tristate = ctrl_q.pump_tristate;
    assign detector_polarity = ctrl_q.detector_polarity;
    assign monitor_output_sel = ctrl_q.monitor_output_sel;
    assign pll_counter_hold = ctrl_q.pll_counter_hold;
    assign rx_lo_enable = lo_en_q;
    assign rx_lo_phase = phase_q.demod_phase_sel[1:0];
    assign mixer_quadrature = quad_q;
    assign mixer_single_q = phase_q.mixer_phase_sel[0];
    assign mixer_phase_sel = phase_q.mixer_phase_sel;
    assign band_clock_divider = phase_q.band_clock_divider;
    assign ref_divide_ratio = tx_q.ref_divide_ratio;
    assign cutoff_cal_start = cal_start_q;
    assign cal_clock_divider = cal_q.cal_clock_divider;
    assign filter_charge_boost = boost_q;
    assign prescaler_sel = lo_q.prescaler_sel;
    assign feedback_mux_sel = lo_q.feedback_mux_sel;
    assign main_divide_count = lo_q.main_divide_count;
    assign swallow_count = lo_q.swallow_count;
    assign rx_filter_bandwidth_sel = rx_q.rx_filter_bandwidth_sel;
    assign rx_gain_sel = rx_q.rx_gain_sel;
    assign factory_test_field = rx_q.factory_test_field;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_shift_msb_first: assert property (
        ce && sclk_rise |=> shift_q == {$past(shift_q[WORD_W-2:0]), $past(sdata)})
        else $error("shift register did not take serial bit");
    a_ctrl_route: assert property (
        ce && strobe_rise && shift_q[SEL_W-1:0] == SEL_CTRL |=> ctrl_q == $past(shift_q))
        else $error("control latch not loaded");
    a_tx_route: assert property (
        ce && strobe_rise && shift_q[SUB_BIT:0] == {SUB_TX, SEL_TXCAL}
        |=> tx_q == $past(shift_q) && $stable(cal_q))
        else $error("transmit latch misrouted");
    a_cal_route: assert property (
        ce && strobe_rise && shift_q[SUB_BIT:0] == {SUB_CAL, SEL_TXCAL}
        |=> cal_q == $past(shift_q) && $stable(tx_q))
        else $error("calibration latch misrouted");
    a_lo_route: assert property (
        ce && strobe_rise && shift_q[SEL_W-1:0] == SEL_LO |=> lo_q == $past(shift_q))
        else $error("divider latch not loaded");
    a_rx_route: assert property (
        ce && strobe_rise && shift_q[SEL_W-1:0] == SEL_RX |=> rx_q == $past(shift_q))
        else $error("filter latch not loaded");
    a_latch_hold: assert property (
        !(ce && strobe_rise) |=> $stable(ctrl_q) && $stable(lo_q) && $stable(rx_q))
        else $error("latch changed without strobe");
    a_osc_mute: assert property (
        ce && ctrl_q.osc_mute_until_lock && !pll_lock |=> !osc_out_enable)
        else $error("oscillator output on before lock");
    a_tx_mute: assert property (
        ce && ctrl_q.transmit_mute_until_lock && !pll_lock |=> !transmit_out_enable)
        else $error("transmit output on before lock");
    a_tx_unmuted: assert property (
        ce && !ctrl_q.transmit_sleep && pll_lock |=> transmit_out_enable)
        else $error("transmit output held off");
    a_cal_start: assert property (
        ce && dest == DST_CAL |=> cutoff_cal_start == $past(shift_q[WORD_W-9]))
        else $error("calibration start wrong");
    a_boost_manual: assert property (
        ce && cal_q.boost_timeout_count == TIMEOUT_MANUAL
        |=> filter_charge_boost == $past(rx_q.filter_charge_boost_enable))
        else $error("manual boost not followed");
    a_pump_max: assert property (
        ce && lo_q.pump_gain_max |=> pump_current_sel == '1)
        else $error("pump current not forced to maximum");
    a_lo_off: assert property (
        ce && phase_d.demod_phase_sel == PHASE_OFF |=> !rx_lo_enable)
        else $error("receive oscillator output not disabled");
    a_cal_idle: assert property (
        ce && dest != DST_CAL |=> !cutoff_cal_start)
        else $error("calibration started without its latch");
    a_osc_unmuted: assert property (
        ce && !ctrl_q.oscillator_sleep && pll_lock |=> osc_out_enable)
        else $error("oscillator output held off");

    c_ctrl_load: cover property (ce && dest == DST_CTRL);
    c_cal_start: cover property (ce && cutoff_cal_start);
    c_boost_timed: cover property (filter_charge_boost && cal_q.boost_timeout_count != '0);
    c_lock_unmute: cover property (!osc_out_enable ##1 osc_out_enable);
    c_manual_boost: cover property (filter_charge_boost && cal_q.boost_timeout_count == '0);
endmodule // rffl_latch_bank

// ### tb/rffl_host_model.sv
// Host-side model of the three-wire serial write port
`timescale 1ns/100ps
module rffl_host_model import rffl_pkg::*; (
    input wire logic clk,
    output logic sclk,
    output logic sdata,
    output logic load_strobe
);
    // Serial clock stands still low between frames
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        load_strobe = 1'b0;
    end

    // Shift a word MSB first, then strobe it in if asked
    task automatic send(input logic [WORD_W-1:0] word, input bit strobe);
        for (int i = WORD_W - 1; i >= 0; i--) begin
            @(negedge clk);
            sclk = 1'b1;
            sdata = word[i];
            @(negedge clk);
            sclk = 1'b0;
            // Hold is over, so show the opposite level, not a stale bit
            sdata = ~word[i];
        end
        if (strobe) begin
            @(negedge clk);
            load_strobe = 1'b1;
            @(negedge clk);
            load_strobe = 1'b0;
        end
    endtask
endmodule // rffl_host_model

// ### tb/rffl_latch_bank_tb.sv
// Self-checking bench for the serial configuration latch bank
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module rffl_latch_bank_tb import rffl_pkg::*; ;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic pll_lock = 1'b0;
    logic ref_tick = 1'b0;
    logic [1:0] tick_cnt = 2'h0;
    logic sclk, sdata, load_strobe;
    logic rx_filter_sleep, pll_sleep, oscillator_sleep, transmit_sleep;
    logic osc_out_enable, transmit_out_enable, pump_tristate, detector_polarity;
    logic pll_counter_hold, rx_lo_enable, mixer_quadrature, mixer_single_q;
    logic cutoff_cal_start, filter_charge_boost, feedback_mux_sel;
    logic [1:0] out_level_sel, lo_level_sel, rx_lo_phase, band_clock_divider;
    logic [1:0] prescaler_sel, rx_filter_bandwidth_sel;
    logic [2:0] pump_current_sel, monitor_output_sel, mixer_phase_sel, rx_gain_sel;
    logic [12:0] ref_divide_ratio, main_divide_count;
    logic [5:0] cal_clock_divider;
    logic [4:0] swallow_count;
    logic [15:0] factory_test_field;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int cal_pulses = 0;
    int boost_ticks = 0;

    initial begin
        forever #20 clk = ~clk;
    end

    // Reference tick every fourth cycle keeps the boost run short
    always @(negedge clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        ref_tick <= (tick_cnt == 2'h3);
    end

    rffl_host_model host (.clk(clk), .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));

    rffl_latch_bank DUT (.clk(clk), .srst(srst), .ce(ce), .sclk(sclk), .sdata(sdata),
        .load_strobe(load_strobe), .pll_lock(pll_lock), .ref_tick(ref_tick),
        .rx_filter_sleep(rx_filter_sleep), .pll_sleep(pll_sleep),
        .oscillator_sleep(oscillator_sleep), .transmit_sleep(transmit_sleep),
        .out_level_sel(out_level_sel), .lo_level_sel(lo_level_sel),
        .pump_current_sel(pump_current_sel), .osc_out_enable(osc_out_enable),
        .transmit_out_enable(transmit_out_enable), .pump_tristate(pump_tristate),
        .detector_polarity(detector_polarity), .monitor_output_sel(monitor_output_sel),
        .pll_counter_hold(pll_counter_hold), .rx_lo_enable(rx_lo_enable),
        .rx_lo_phase(rx_lo_phase), .mixer_quadrature(mixer_quadrature),
        .mixer_single_q(mixer_single_q), .mixer_phase_sel(mixer_phase_sel),
        .band_clock_divider(band_clock_divider), .ref_divide_ratio(ref_divide_ratio),
        .cutoff_cal_start(cutoff_cal_start), .cal_clock_divider(cal_clock_divider),
        .filter_charge_boost(filter_charge_boost), .prescaler_sel(prescaler_sel),
        .feedback_mux_sel(feedback_mux_sel), .main_divide_count(main_divide_count),
        .swallow_count(swallow_count), .rx_filter_bandwidth_sel(rx_filter_bandwidth_sel),
        .rx_gain_sel(rx_gain_sel), .factory_test_field(factory_test_field));

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Pulse and tick counters, plus the hang limit
    always @(posedge clk) begin
        cycles++;
        if (cutoff_cal_start === 1'b1)
            cal_pulses++;
        if (filter_charge_boost === 1'b1 && ref_tick === 1'b1)
            boost_ticks++;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end

    // Registered outputs lag the latch by one cycle, so wait past both
    task automatic wr(input logic [23:0] w);
        host.send(w, 1'b1);
        repeat (3) @(negedge clk);
    endtask

    initial begin
        repeat (4) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        `CHK("sleep", 4'hF, {rx_filter_sleep, pll_sleep, oscillator_sleep, transmit_sleep})
        `CHK("rx_lo_enable", 1'b0, rx_lo_enable)
        `CHK("quadrature", 1'b1, mixer_quadrature)
        $display("test reset done");

        // Spare bits 3:2 always sent as 0,1; bit 2 set must not divert select 00
        for (int i = 0; i < 4; i++) begin
            wr(24'h000004 | (24'h080000 << i));
            `CHK("sleep", 4'h1 << i, {rx_filter_sleep, pll_sleep, oscillator_sleep, transmit_sleep})
            `CHK("tx_enable", (i != 0), transmit_out_enable)
            `CHK("osc_enable", (i != 1), osc_out_enable)
        end
        `CHK("pll_flags", 3'h0, {pump_tristate, detector_polarity, pll_counter_hold})
        wr(24'h055FD4);
        `CHK("out_level", 2'h2, out_level_sel)
        `CHK("lo_level", 2'h1, lo_level_sel)
        `CHK("pump_current", 3'h5, pump_current_sel)
        `CHK("pll_flags", 3'h7, {pump_tristate, detector_polarity, pll_counter_hold})
        `CHK("monitor", 3'h6, monitor_output_sel)
        `CHK("muted", 2'h0, {osc_out_enable, transmit_out_enable})
        pll_lock = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("unmuted", 2'h3, {osc_out_enable, transmit_out_enable})
        pll_lock = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("remuted", 2'h0, {osc_out_enable, transmit_out_enable})
        $display("test control done");

        // Band clock always programmed as divide-by-8
        wr(24'h57FFF9);
        `CHK("rx_lo_enable", 1'b1, rx_lo_enable)
        `CHK("rx_lo_phase", 2'h2, rx_lo_phase)
        `CHK("mixer", 3'h3, {mixer_quadrature, mixer_single_q, 1'b1})
        `CHK("mixer_code", 3'h5, mixer_phase_sel)
        `CHK("band_clock", 2'h3, band_clock_divider)
        `CHK("ref_ratio", 13'h1FFF, ref_divide_ratio)
        wr(24'h570009);
        `CHK("ref_ratio", 13'h0001, ref_divide_ratio)
        $display("test transmit done");

        cal_pulses = 0;
        boost_ticks = 0;
        wr(24'hE3841D);
        `CHK("cal_divider", 6'h02, cal_clock_divider)
        `CHK("rx_lo_off", 1'b0, rx_lo_enable)
        `CHK("cal_pulses", 1, cal_pulses)
        repeat (60) @(negedge clk);
        // Ratio 2 times timeout 3; one tick of slack for the load alignment
        `CHK("boost_ticks", 1'b1, (boost_ticks >= 5 && boost_ticks <= 7))
        `CHK("boost_end", 1'b0, filter_charge_boost)
        wr(24'hE30405);
        `CHK("cal_pulses", 1, cal_pulses)
        $display("test calibration done");

        wr(24'hA5C3CF);
        `CHK("boost_manual", 1'b1, filter_charge_boost)
        `CHK("bandwidth", 2'h2, rx_filter_bandwidth_sel)
        `CHK("gain", 3'h3, rx_gain_sel)
        `CHK("test_field", 16'hA5C3, factory_test_field)
        // Manual bit cleared again for normal receive
        wr(24'hA5C34F);
        `CHK("boost_manual", 1'b0, filter_charge_boost)
        host.send(24'hFFFFFF, 1'b0);
        repeat (3) @(negedge clk);
        `CHK("no_strobe", 2'h2, rx_filter_bandwidth_sel)
        // Enable low freezes shift and latches, so this boost word is lost
        ce = 1'b0;
        wr(24'hA5C3CF);
        ce = 1'b1;
        repeat (3) @(negedge clk);
        `CHK("frozen", 1'b0, filter_charge_boost)
        $display("test filter done");

        wr(24'hB55E7E);
        `CHK("prescaler", 2'h2, prescaler_sel)
        `CHK("feedback", 1'b1, feedback_mux_sel)
        `CHK("main_count", 13'h0ABC, main_divide_count)
        `CHK("swallow", 5'h1F, swallow_count)
        `CHK("pump_max", 3'h7, pump_current_sel)
        `CHK("gain_kept", 3'h3, rx_gain_sel)
        `CHK("ref_kept", 13'h0001, ref_divide_ratio)
        $display("test divider done");
        complete_run();
    end
endmodule // rffl_latch_bank_tb
